/* File: adc_cfg_pkg.sv */
// constants, field layouts and carrier types for the converter control register bank
// assumes 8-bit registers in a 12-bit address space reached over a three-wire serial programming port
package adc_cfg_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_SOFT_RESET = 12'h000;
    localparam logic [11:0] ADDR_IF_CFG = 12'h007;
    localparam logic [11:0] ADDR_POWER = 12'h008;
    localparam logic [11:0] ADDR_PD_MASK = 12'h00D;
    localparam logic [11:0] ADDR_FUSE_LOAD = 12'h013;

    localparam logic [7:0] REG_DEFAULT = 8'h00;
    localparam logic [2:0] FIELD_ZERO = 3'h0;

    // ------------------------------------------------------------------
    // bit positions
    // ------------------------------------------------------------------
    localparam int SOFT_RESET_BIT = 0;
    localparam int FUSE_LOAD_BIT = 0;
    localparam int PWR_CLKBUF_BIT = 5;
    localparam int PWR_REFAMP_BIT = 4;
    localparam int PWR_CHAN_A_BIT = 2;
    localparam int PWR_CHAN_B_BIT = 1;
    localparam int PWR_GLOBAL_BIT = 0;
    localparam int KEEP_CLOCK_BUFFER_ON_BIT = 3;
    localparam int MASK_REFAMP_BIT = 2;
    localparam int MASK_BANDGAP_BIT = 1;

    // ------------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_WORD_BITS = 5'h10;
    localparam logic [4:0] LAST_BIT_INDEX = 5'h17;
    localparam logic [4:0] COUNT_LIMIT = 5'h18;
    localparam int RW_BIT = 15;

    // ------------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------------
    localparam logic [2:0] MAP_TWO_LANE_18_14 = 3'h1;
    localparam logic [2:0] MAP_TWO_LANE_16 = 3'h2;
    localparam logic [2:0] MAP_ONE_LANE = 3'h3;
    localparam logic [2:0] MAP_HALF_LANE = 3'h4;
    localparam logic [2:0] LANE_TWO = 3'h3;
    localparam logic [2:0] LANE_ONE = 3'h4;
    localparam logic [2:0] LANE_HALF = 3'h5;

    // fuse-held defaults
    localparam logic [2:0] FUSE_DEFAULT_MAPPING = 3'h1;
    localparam logic [2:0] FUSE_DEFAULT_LANE = 3'h3;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] lane_bit_mapping;
        logic reserved;
        logic lane_mode_override;
        logic [2:0] lane_mode_select;
    } if_cfg_t;

    typedef struct packed {
        logic sample_clock_buffer_off;
        logic reference_amp_off;
        logic channel_a_off;
        logic channel_b_off;
        logic bandgap_off;
        logic global_sleep;
    } power_state_t;

    typedef struct packed {
        logic map_two_lane_18_14;
        logic map_two_lane_16;
        logic map_one_lane;
        logic map_half_lane;
        logic lane_two;
        logic lane_one;
        logic lane_half;
    } lane_state_t;

endpackage

/* File: adc_config_power_regs.sv */
// control register bank: soft reset, output interface mapping, lane mode and power down
// assumes the serial clock is slower than mclk/8 and that pins are asynchronous to mclk
`timescale 1ns/1ps
module adc_config_power_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_select_n,
    input wire logic serial_clk,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_n,
    output adc_cfg_pkg::power_state_t power,
    output adc_cfg_pkg::lane_state_t lanes,
    output logic [2:0] active_bit_mapping,
    output logic [2:0] active_lane_mode
);

    // ------------------------------------------------------------------
    // pin synchronisation and serial clock edges
    // ------------------------------------------------------------------
    logic [2:0] pins_s;
    logic sclk_d_reg;

    pin_sync #(
        .WIDTH(3),
        .RESET_VALUE(3'h4)
    ) u_pin_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin({serial_select_n, serial_clk, sdio_in}),
        .pin_sync(pins_s)
    );

    wire sen_s = pins_s[2];
    wire sclk_s = pins_s[1];
    wire sdio_s = pins_s[0];
    wire frame_on = ~sen_s;
    wire sclk_rise = frame_on & sclk_s & ~sclk_d_reg;
    wire sclk_fall = frame_on & ~sclk_s & sclk_d_reg;

    // ------------------------------------------------------------------
    // serial frame engine
    // ------------------------------------------------------------------
    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic [22:0] shift_reg;
    logic [22:0] shift_next;
    logic [7:0] rd_shift_reg;
    logic [7:0] rd_shift_next;
    logic drive_reg;
    logic drive_next;

    wire [23:0] frame_word = {shift_reg, sdio_s};
    wire count_full = (count_reg == adc_cfg_pkg::COUNT_LIMIT);
    wire addr_done = (count_reg == adc_cfg_pkg::ADDR_WORD_BITS);
    wire read_req = shift_reg[adc_cfg_pkg::RW_BIT] & (shift_reg[14:12] == adc_cfg_pkg::FIELD_ZERO);
    wire read_load = sclk_fall & addr_done & read_req & ~drive_reg;
    wire read_shift = sclk_fall & drive_reg & (count_reg > adc_cfg_pkg::ADDR_WORD_BITS);
    wire wr_strobe = sclk_rise & (count_reg == adc_cfg_pkg::LAST_BIT_INDEX)
                     & ~frame_word[23] & (frame_word[22:20] == adc_cfg_pkg::FIELD_ZERO);
    wire [11:0] wr_addr = frame_word[19:8];
    wire [7:0] wr_data = frame_word[7:0];
    wire [11:0] rd_addr = shift_reg[11:0];

    assign count_next = !frame_on ? 5'h00 : (sclk_rise & ~count_full) ? count_reg + 5'h01 : count_reg;
    assign shift_next = !frame_on ? 23'h00_0000 : sclk_rise ? frame_word[22:0] : shift_reg;
    assign drive_next = frame_on & (drive_reg | read_load);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    adc_cfg_pkg::if_cfg_t if_cfg_reg;
    adc_cfg_pkg::if_cfg_t if_cfg_next;
    logic [7:0] power_reg;
    logic [7:0] power_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic cfg_written_reg;
    logic cfg_written_next;
    logic [2:0] applied_map_reg;
    logic [2:0] applied_map_next;

    wire soft_reset = wr_strobe & (wr_addr == adc_cfg_pkg::ADDR_SOFT_RESET)
                      & wr_data[adc_cfg_pkg::SOFT_RESET_BIT];
    wire fuse_load = wr_strobe & (wr_addr == adc_cfg_pkg::ADDR_FUSE_LOAD)
                     & wr_data[adc_cfg_pkg::FUSE_LOAD_BIT];
    wire wr_cfg = wr_strobe & (wr_addr == adc_cfg_pkg::ADDR_IF_CFG);
    wire wr_power = wr_strobe & (wr_addr == adc_cfg_pkg::ADDR_POWER);
    wire wr_mask = wr_strobe & (wr_addr == adc_cfg_pkg::ADDR_PD_MASK);

    // soft reset returns everything to defaults; the bit itself is never stored
    assign if_cfg_next = soft_reset ? adc_cfg_pkg::if_cfg_t'(adc_cfg_pkg::REG_DEFAULT)
                         : wr_cfg ? adc_cfg_pkg::if_cfg_t'(wr_data) : if_cfg_reg;
    assign cfg_written_next = soft_reset ? 1'b0 : (cfg_written_reg | wr_cfg);
    // fuse load discards earlier serial writes to the power and power-down mask registers
    assign power_next = (soft_reset | fuse_load) ? adc_cfg_pkg::REG_DEFAULT
                        : wr_power ? wr_data : power_reg;
    assign mask_next = (soft_reset | fuse_load) ? adc_cfg_pkg::REG_DEFAULT
                       : wr_mask ? wr_data : mask_reg;
    // mapping moves into effect only on fuse load
    assign applied_map_next = soft_reset ? adc_cfg_pkg::FUSE_DEFAULT_MAPPING
                              : !fuse_load ? applied_map_reg
                              : cfg_written_reg ? if_cfg_reg.lane_bit_mapping
                              : adc_cfg_pkg::FUSE_DEFAULT_MAPPING;

    // ------------------------------------------------------------------
    // readback
    // ------------------------------------------------------------------
    wire [7:0] rd_data = (rd_addr == adc_cfg_pkg::ADDR_IF_CFG) ? if_cfg_reg
                         : (rd_addr == adc_cfg_pkg::ADDR_POWER) ? power_reg
                         : (rd_addr == adc_cfg_pkg::ADDR_PD_MASK) ? mask_reg
                         : adc_cfg_pkg::REG_DEFAULT;

    assign rd_shift_next = read_load ? rd_data : read_shift ? {rd_shift_reg[6:0], 1'b0} : rd_shift_reg;

    // ------------------------------------------------------------------
    // effective controls
    // ------------------------------------------------------------------
    wire global_on = power_reg[adc_cfg_pkg::PWR_GLOBAL_BIT];
    adc_cfg_pkg::power_state_t power_state_next;
    adc_cfg_pkg::lane_state_t lanes_next;
    wire [2:0] lane_mode_next = if_cfg_reg.lane_mode_override ? if_cfg_reg.lane_mode_select
                                : adc_cfg_pkg::FUSE_DEFAULT_LANE;

    assign power_state_next.sample_clock_buffer_off = power_reg[adc_cfg_pkg::PWR_CLKBUF_BIT]
        | (global_on & ~mask_reg[adc_cfg_pkg::KEEP_CLOCK_BUFFER_ON_BIT]);
    assign power_state_next.reference_amp_off = power_reg[adc_cfg_pkg::PWR_REFAMP_BIT]
        | (global_on & ~mask_reg[adc_cfg_pkg::MASK_REFAMP_BIT]);
    assign power_state_next.channel_a_off = power_reg[adc_cfg_pkg::PWR_CHAN_A_BIT] | global_on;
    assign power_state_next.channel_b_off = power_reg[adc_cfg_pkg::PWR_CHAN_B_BIT] | global_on;
    assign power_state_next.bandgap_off = global_on & mask_reg[adc_cfg_pkg::MASK_BANDGAP_BIT];
    assign power_state_next.global_sleep = global_on;

    assign lanes_next.map_two_lane_18_14 = (applied_map_reg == adc_cfg_pkg::MAP_TWO_LANE_18_14);
    assign lanes_next.map_two_lane_16 = (applied_map_reg == adc_cfg_pkg::MAP_TWO_LANE_16);
    assign lanes_next.map_one_lane = (applied_map_reg == adc_cfg_pkg::MAP_ONE_LANE);
    assign lanes_next.map_half_lane = (applied_map_reg == adc_cfg_pkg::MAP_HALF_LANE);
    assign lanes_next.lane_two = (lane_mode_next == adc_cfg_pkg::LANE_TWO);
    assign lanes_next.lane_one = (lane_mode_next == adc_cfg_pkg::LANE_ONE);
    assign lanes_next.lane_half = (lane_mode_next == adc_cfg_pkg::LANE_HALF);

    assign sdio_out = rd_shift_reg[7];
    assign sdio_oe_n = ~drive_reg;

    // ------------------------------------------------------------------
    // flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sclk_d_reg <= 1'b0;
            count_reg <= 5'h00;
            shift_reg <= 23'h00_0000;
            rd_shift_reg <= adc_cfg_pkg::REG_DEFAULT;
            drive_reg <= 1'b0;
        end
        else
        begin
            sclk_d_reg <= sclk_s;
            count_reg <= count_next;
            shift_reg <= shift_next;
            rd_shift_reg <= rd_shift_next;
            drive_reg <= drive_next;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            if_cfg_reg <= adc_cfg_pkg::if_cfg_t'(adc_cfg_pkg::REG_DEFAULT);
            power_reg <= adc_cfg_pkg::REG_DEFAULT;
            mask_reg <= adc_cfg_pkg::REG_DEFAULT;
            cfg_written_reg <= 1'b0;
            applied_map_reg <= adc_cfg_pkg::FUSE_DEFAULT_MAPPING;
        end
        else
        begin
            if_cfg_reg <= if_cfg_next;
            power_reg <= power_next;
            mask_reg <= mask_next;
            cfg_written_reg <= cfg_written_next;
            applied_map_reg <= applied_map_next;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            power <= '0;
            lanes <= '{map_two_lane_18_14: 1'b1, lane_two: 1'b1, default: 1'b0};
            active_bit_mapping <= adc_cfg_pkg::FUSE_DEFAULT_MAPPING;
            active_lane_mode <= adc_cfg_pkg::FUSE_DEFAULT_LANE;
        end
        else
        begin
            power <= power_state_next;
            lanes <= lanes_next;
            active_bit_mapping <= applied_map_reg;
            active_lane_mode <= lane_mode_next;
        end
    end

endmodule

/* File: cfg_regs_asserts.sv */
// checker for the control register bank, port level only
// assumes a single mclk domain with synchronous active-low reset
`timescale 1ns/1ps
module cfg_regs_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_select_n,
    input wire logic serial_clk,
    input wire logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    input wire adc_cfg_pkg::power_state_t power,
    input wire adc_cfg_pkg::lane_state_t lanes,
    input wire logic [2:0] active_bit_mapping,
    input wire logic [2:0] active_lane_mode
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_global_chan_a: assert property (power.global_sleep |-> power.channel_a_off)
        else $error("channel a on in global power down");
    a_global_chan_b: assert property (power.global_sleep |-> power.channel_b_off)
        else $error("channel b on in global power down");
    a_lane_half_flag: assert property ((active_lane_mode == adc_cfg_pkg::LANE_HALF) [*3]
        |-> lanes.lane_half)
        else $error("half lane flag missing");
    a_lane_one_hot: assert property (lanes.lane_one |-> !lanes.lane_two && !lanes.lane_half)
        else $error("lane flags not exclusive");
    a_map_half_flag: assert property ((active_bit_mapping == adc_cfg_pkg::MAP_HALF_LANE) [*3]
        |-> lanes.map_half_lane)
        else $error("half lane mapping flag missing");
    a_idle_no_drive: assert property (serial_select_n [*8] |-> sdio_oe_n)
        else $error("data line driven outside a frame");
    a_reset_values: assert property ($rose(rst_n) |-> power == 6'h00 && lanes == 7'h44
        && active_bit_mapping == 3'h1 && active_lane_mode == 3'h3)
        else $error("wrong outputs after reset");
    a_idle_stable: assert property (serial_select_n [*8] |-> $stable(power) && $stable(active_bit_mapping))
        else $error("outputs changed without a frame");
endmodule

/* File: pin_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to mclk; reset value is a constant per bit
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            stage1_reg <= RESET_VALUE;
            pin_sync <= RESET_VALUE;
        end
        else
        begin
            stage1_reg <= pin;
            pin_sync <= stage1_reg;
        end
    end

endmodule

/* File: spi_host.sv */
// model of the external controller on the serial programming port
// assumes mclk at 20 MHz; serial clock half period is six mclk cycles
`timescale 1ns/1ps
module spi_host (
    input wire logic mclk,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    output logic serial_select_n,
    output logic serial_clk,
    output logic sdio_in
);
    localparam int HALF = 6;
    logic host_bit = 1'b0;
    logic host_drive = 1'b1;
    logic last_bit = 1'b0;
    initial serial_select_n = 1'b1;
    initial serial_clk = 1'b0;
    // released line shows the inverse of the last driven bit
    assign sdio_in = !sdio_oe_n ? sdio_out : (host_drive ? host_bit : !last_bit);
    task automatic frame(input logic [15:0] aw, input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] word;
        word = {aw, wd};
        rd = 8'h00;
        serial_select_n <= 1'b0;
        repeat (HALF) @(posedge mclk);
        for (int i = 23; i >= 0; i--)
        begin
            serial_clk <= 1'b0;
            host_drive <= !(aw[15] && i < 8);
            host_bit <= word[i];
            last_bit <= word[i];
            repeat (HALF) @(posedge mclk);
            if (i < 8)
                rd = {rd[6:0], sdio_in};
            serial_clk <= 1'b1;
            repeat (HALF) @(posedge mclk);
        end
        serial_clk <= 1'b0;
        host_drive <= 1'b1;
        repeat (HALF) @(posedge mclk);
        serial_select_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
    task automatic write_reg(input logic [11:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        frame({4'h0, addr}, data, unused);
    endtask
    task automatic read_reg(input logic [11:0] addr, output logic [7:0] data);
        frame({4'h8, addr}, 8'h00, data);
    endtask
endmodule

/* File: tb_top.sv */
// testbench for the control register bank
// assumes the host model in spi_host and the checker in cfg_regs_asserts
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic serial_select_n, serial_clk, sdio_in, sdio_out, sdio_oe_n;
    adc_cfg_pkg::power_state_t power;
    adc_cfg_pkg::lane_state_t lanes;
    logic [2:0] active_bit_mapping, active_lane_mode;
    int miscompares = 0;
    int num_checks = 0;
    logic [7:0] rd;
    logic [2:0] m_tab [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    logic [2:0] l_tab [4] = '{3'h3, 3'h4, 3'h5, 3'h0};
    int b_tab [4] = '{5, 4, 2, 1};
    logic [5:0] p_tab [4] = '{6'h20, 6'h10, 6'h08, 6'h04};
    always #25 mclk = !mclk;
    adc_config_power_regs u_adc_config_power_regs (.mclk(mclk), .rst_n(rst_n), .serial_select_n(serial_select_n),
        .serial_clk(serial_clk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .power(power),
        .lanes(lanes), .active_bit_mapping(active_bit_mapping), .active_lane_mode(active_lane_mode));
    spi_host u_spi_host (.mclk(mclk), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
        .serial_select_n(serial_select_n), .serial_clk(serial_clk), .sdio_in(sdio_in));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [6:0] exp_lanes(input logic [2:0] m, input logic [2:0] l);
        return {m == 3'h1, m == 3'h2, m == 3'h3, m == 3'h4, l == 3'h3, l == 3'h4, l == 3'h5};
    endfunction
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check("map", active_bit_mapping, 16'h0001);
        check("lanes", lanes, 16'h0044);
        u_spi_host.read_reg(12'h007, rd);
        check("rd07", rd, 16'h0000);
        u_spi_host.write_reg(12'h007, 8'h45);
        check("mode", active_lane_mode, 16'h0003);
        u_spi_host.read_reg(12'h007, rd);
        check("rd07", rd, 16'h0045);
        for (int i = 0; i < 4; i++)
        begin
            u_spi_host.write_reg(12'h007, {m_tab[i], 2'b01, l_tab[i]});
            check("map", active_bit_mapping, (i == 0) ? 16'h0001 : 16'(m_tab[i - 1]));
            check("mode", active_lane_mode, 16'(l_tab[i]));
            u_spi_host.write_reg(12'h013, 8'h01);
            check("map", active_bit_mapping, 16'(m_tab[i]));
            check("lanes", lanes, 16'(exp_lanes(m_tab[i], l_tab[i])));
        end
        for (int i = 0; i < 4; i++)
        begin
            u_spi_host.write_reg(12'h008, 8'(1 << b_tab[i]));
            check("power", power, 16'(p_tab[i]));
            u_spi_host.read_reg(12'h008, rd);
            check("rd08", rd, 16'(8'(1 << b_tab[i])));
        end
        u_spi_host.write_reg(12'h00D, 8'h0E);
        u_spi_host.write_reg(12'h008, 8'h01);
        check("power", power, 16'h000F);
        u_spi_host.write_reg(12'h013, 8'h01);
        check("power", power, 16'h0000);
        check("map", active_bit_mapping, 16'h0004);
        u_spi_host.read_reg(12'h008, rd);
        check("rd08", rd, 16'h0000);
        u_spi_host.read_reg(12'h00D, rd);
        check("rd0d", rd, 16'h0000);
        u_spi_host.write_reg(12'h00D, 8'h08);
        u_spi_host.write_reg(12'h008, 8'h01);
        check("power", power, 16'h001D);
        u_spi_host.write_reg(12'h00D, 8'h00);
        check("power", power, 16'h003D);
        u_spi_host.write_reg(12'h008, 8'h00);
        check("power", power, 16'h0000);
        u_spi_host.frame(16'h1008, 8'h20, rd);
        check("power", power, 16'h0000);
        u_spi_host.write_reg(12'h008, 8'h30);
        check("power", power, 16'h0030);
        u_spi_host.write_reg(12'h000, 8'h01);
        check("power", power, 16'h0000);
        check("map", active_bit_mapping, 16'h0001);
        u_spi_host.read_reg(12'h007, rd);
        check("rd07", rd, 16'h0000);
        u_spi_host.read_reg(12'h000, rd);
        check("rd00", rd, 16'h0000);
        finish_test();
    end
    initial
    begin
        repeat (30000) @(posedge mclk);
        miscompares++;
        finish_test();
    end
endmodule
bind adc_config_power_regs cfg_regs_asserts u_cfg_regs_asserts (.mclk(mclk), .rst_n(rst_n),
    .serial_select_n(serial_select_n), .serial_clk(serial_clk), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .power(power), .lanes(lanes), .active_bit_mapping(active_bit_mapping),
    .active_lane_mode(active_lane_mode));
